// ===== tb/timer_mode_and_io_control_chk.sv
// Purpose: port-level checker for the timer mode and I/O control block
// Assumes: one clock domain, reset asynchronous and active low
// Notes: watches design ports only, bus and event inputs as well as outputs, attached by bind
`timescale 1ns/100ps
module timer_mode_and_io_control_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input timer_io_pkg::timer_events_type events,
  input timer_io_pkg::pin_drive_type pin_drive,
  input wire logic [19:0] capture_strobe,
  input wire logic [4:0] counter_run,
  input wire logic [4:0] buffer_pair_ac,
  input wire logic [4:0] buffer_pair_bd,
  input wire logic [19:0] effective_mode
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  function automatic logic rsv(input logic [3:0] m);
    return m == 4'h1 || (m >= 4'h9 && m <= 4'hC);
  endfunction
  logic any_rsv;
  assign any_rsv = rsv(effective_mode[3:0]) || rsv(effective_mode[7:4])
    || rsv(effective_mode[11:8]) || rsv(effective_mode[15:12]) || rsv(effective_mode[19:16]);
  sequence s_release;
    $rose(presetn);
  endsequence
  sequence s_quiet_run;
    counter_run[0] && !events.compare_match[0] && !events.counter_clear[0];
  endsequence
  a_ready_access: assert property (pready == (psel && penable))
    else $error("ready does not follow the access phase");
  a_reset_quiet: assert property (s_release |->
    pin_drive.level == 20'h0 && effective_mode == 20'h0 && counter_run == 5'h0)
    else $error("outputs not quiet after reset");
  a_phase_channels: assert property (effective_mode[3:2] != 2'h1 &&
    effective_mode[15:14] != 2'h1 && effective_mode[19:18] != 2'h1)
    else $error("phase counting on a wrong channel");
  a_sync_ch3_only: assert property (!effective_mode[3] && !effective_mode[7]
    && !effective_mode[11]) else $error("ch3-only mode on another channel");
  a_no_reserved: assert property (!any_rsv)
    else $error("reserved mode code effective");
  a_pwm2_low_ch: assert property (effective_mode[15:12] != 4'h3 &&
    effective_mode[19:16] != 4'h3) else $error("pwm2 on channel 3 or 4");
  a_ch4_follows: assert property (effective_mode[15] |->
    effective_mode[19:16] == effective_mode[15:12]) else $error("ch4 does not follow ch3");
  a_buffer_quiet: assert property (buffer_pair_ac[0] |->
    !pin_drive.oe[2] && !capture_strobe[2]) else $error("buffer register still active");
  a_missing_regs: assert property (pin_drive.oe[7:6] == 2'h0 &&
    pin_drive.oe[11:10] == 2'h0 && capture_strobe[7:6] == 2'h0 &&
    capture_strobe[11:10] == 2'h0 && buffer_pair_ac[2:1] == 2'h0 && buffer_pair_bd[2:1] == 2'h0)
    else $error("absent register active");
  a_run_holds_level: assert property (s_quiet_run |=> $stable(pin_drive.level[0]))
    else $error("running pin changed without an event");
endmodule
bind timer_mode_and_io_control timer_mode_and_io_control_chk i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .events(events), .pin_drive(pin_drive), .capture_strobe(capture_strobe),
  .counter_run(counter_run), .buffer_pair_ac(buffer_pair_ac),
  .buffer_pair_bd(buffer_pair_bd), .effective_mode(effective_mode));

// ===== tb/timer_mode_and_io_control_tb.sv
// Purpose: self-checking bench for the timer mode and I/O control block
// Assumes: zero-wait APB slave, register map of the package
// Notes: pin index is channel * 4 + letter
`timescale 1ns/100ps
module timer_mode_and_io_control_tb;
  localparam logic [11:0] IO0 = 12'h020;
  localparam logic [11:0] RUN = 12'h040;
  localparam logic [11:0] EFF = 12'h044;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  timer_io_pkg::timer_events_type events;
  timer_io_pkg::pin_drive_type pin_drive;
  logic [19:0] pin_in, capture_strobe, effective_mode;
  logic [4:0] counter_run, buffer_pair_ac, buffer_pair_bd;
  int fails, check_count, b;
  int cap_cnt [20];
  timer_mode_and_io_control i_timer_mode_and_io_control (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .events(events), .pin_in(pin_in), .pin_drive(pin_drive),
    .capture_strobe(capture_strobe), .counter_run(counter_run),
    .buffer_pair_ac(buffer_pair_ac), .buffer_pair_bd(buffer_pair_bd),
    .effective_mode(effective_mode));
  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) for (int i = 0; i < 20; i++) if (capture_strobe[i] === 1'h1) cap_cnt[i]++;
  task wrap_up;
    if (fails == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task cmp(input string nm, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, x, g);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
    // let the registered status outputs take the new value
    repeat (2) @(posedge pclk);
  endtask
  task rd(input logic [11:0] a, input string nm, input logic [31:0] x);
    apb(1'h0, a, 32'h0);
    cmp(nm, x, q);
  endtask
  task pulse(input logic [25:0] v);
    @(posedge pclk) events <= v;
    @(posedge pclk) events <= 26'h0;
    repeat (3) @(posedge pclk);
  endtask
  task lvl(input logic x);
    repeat (3) @(posedge pclk);
    cmp("pin level", 32'(x), 32'(pin_drive.level[0]));
  endtask
  function automatic logic [3:0] legal(input int c, input logic [3:0] m);
    case (m)
      4'h0, 4'h2: return m;
      4'h3: return (c < 3) ? m : 4'h0;
      4'h4, 4'h5, 4'h6, 4'h7: return (c == 1 || c == 2) ? m : 4'h0;
      4'h8, 4'hD, 4'hE, 4'hF: return (c == 3) ? m : 4'h0;
      default: return 4'h0;
    endcase
  endfunction
  task t_reset;
    for (int c = 0; c < 5; c++) rd(12'(4 * c), "mode", 32'hC0);
    for (int r = 0; r < 8; r++) rd(IO0 + 12'(4 * r), "io", 32'h0);
    rd(12'h048, "pins", 32'h0);
  endtask
  task t_modes;
    logic [31:0] x;
    for (int c = 0; c < 5; c++) begin
      for (int m = 0; m < 16; m++) begin
        wr(12'(4 * c), 32'(m));
        x = 32'(legal(c, 4'(m))) << (4 * c);
        x = x | ((c == 3 && x[15]) ? (x << 4) : 32'h0);
        rd(EFF, "eff mode", x);
        cmp("eff port", x, 32'(effective_mode));
      end
      wr(12'(4 * c), 32'h0);
    end
  endtask
  task t_follow;
    logic [3:0] fc [4];
    fc = '{4'h8, 4'hD, 4'hE, 4'hF};
    wr(12'h010, 32'h2);
    foreach (fc[i]) begin
      wr(12'h00C, 32'(fc[i]));
      rd(EFF, "follow", (32'(fc[i]) << 16) | (32'(fc[i]) << 12));
    end
    wr(12'h00C, 32'h0);
    rd(EFF, "own ch4", 32'h20000);
    wr(12'h010, 32'h0);
  endtask
  task t_io;
    for (int r = 0; r < 8; r++) begin
      wr(IO0 + 12'(4 * r), 32'hA5 ^ 32'(r));
      rd(IO0 + 12'(4 * r), "io rw", 32'hA5 ^ 32'(r));
      wr(IO0 + 12'(4 * r), 32'h0);
    end
    wr(IO0, 32'h85);
    cmp("oe ab", 32'h1, 32'(pin_drive.oe[1:0]));
    wr(IO0, 32'h58);
    cmp("oe ba", 32'h2, 32'(pin_drive.oe[1:0]));
  endtask
  task t_levels;
    wr(IO0, 32'h05);
    lvl(1'h1);
    wr(IO0, 32'h03);
    lvl(1'h0);
    wr(RUN, 32'h1);
    cmp("run port", 32'h1, 32'(counter_run));
    pulse(26'h40);
    lvl(1'h1);
    pulse(26'h40);
    lvl(1'h0);
    wr(IO0, 32'h06);
    lvl(1'h0);
    pulse(26'h40);
    lvl(1'h1);
    wr(IO0, 32'h05);
    pulse(26'h40);
    lvl(1'h0);
    wr(IO0, 32'h02);
    pulse(26'h40);
    lvl(1'h1);
    wr(IO0, 32'h01);
    pulse(26'h40);
    lvl(1'h0);
    wr(RUN, 32'h0);
    wr(12'h000, 32'h3);
    wr(IO0, 32'h07);
    wr(RUN, 32'h1);
    pulse(26'h40);
    lvl(1'h0);
    pulse(26'h2);
    lvl(1'h1);
    wr(RUN, 32'h0);
    wr(12'h000, 32'h0);
  endtask
  task cap(input logic [3:0] code, input int er, input int ef);
    wr(IO0, 32'(code));
    b = cap_cnt[0];
    @(posedge pclk) pin_in[0] <= 1'h1;
    repeat (6) @(posedge pclk);
    cmp("rise capture", er, cap_cnt[0] - b);
    b = cap_cnt[0];
    @(posedge pclk) pin_in[0] <= 1'h0;
    repeat (6) @(posedge pclk);
    cmp("fall capture", ef, cap_cnt[0] - b);
  endtask
  task t_special;
    wr(IO0, 32'h0C);
    b = cap_cnt[0];
    pulse(26'h1);
    cmp("count capture", 1, cap_cnt[0] - b);
    wr(12'h024, 32'h01);
    wr(12'h028, 32'hC0);
    b = cap_cnt[5];
    pulse(26'h100);
    cmp("c match capture", 1, cap_cnt[5] - b);
    wr(12'h000, 32'h30);
    cmp("pair ac", 32'h1, 32'(buffer_pair_ac[0]));
    cmp("pair bd", 32'h1, 32'(buffer_pair_bd[0]));
    cmp("buffer oe", 32'h0, 32'(pin_drive.oe[2]));
    b = cap_cnt[5];
    pulse(26'h100);
    cmp("buffer no event", 0, cap_cnt[5] - b);
    wr(12'h004, 32'h30);
    rd(12'h004, "ch1 pair", 32'hC0);
    wr(12'h000, 32'h0);
    wr(12'h024, 32'h0);
    wr(12'h028, 32'h0);
    wr(IO0, 32'h0);
  endtask
  initial begin
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    events = 26'h0;
    pin_in = 20'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    t_modes();
    t_follow();
    t_io();
    t_levels();
    cap(4'h8, 1, 0);
    cap(4'h9, 0, 1);
    cap(4'hA, 1, 1);
    cap(4'hB, 1, 1);
    t_special();
    rd(12'h0FC, "unmapped data", 32'h0);
    cmp("unmapped error", 32'h1, 32'(e));
    wrap_up();
  end
  initial begin
    #300000;
    fails++;
    wrap_up();
  end
endmodule

// ===== verilog/timer_io_pkg.sv
// Purpose: shared constants and types for the timer mode and I/O control block
// Assumes: APB register access, 32-bit data, word-aligned registers
// Notes: general register index is channel * 4 + letter (A=0, B=1, C=2, D=3)
package timer_io_pkg;

  localparam int NUM_CH = 5;
  localparam int NUM_GR = 20;
  localparam int NUM_IO = 8;
  localparam int ADDR_W = 12;

  // register map
  localparam logic [11:0] MODE_BASE = 12'h000;
  localparam logic [11:0] IO_BASE = 12'h020;
  localparam logic [11:0] RUN_OFFSET = 12'h040;
  localparam logic [11:0] EFF_MODE_OFFSET = 12'h044;
  localparam logic [11:0] PIN_LEVEL_OFFSET = 12'h048;

  // mode register fields
  localparam int MODE_FIELD_LSB = 0;
  localparam int MODE_FIELD_W = 4;
  localparam int BUF_PAIR_AC_BIT = 4;
  localparam int BUF_PAIR_BD_BIT = 5;
  localparam logic [7:0] MODE_RESERVED_ONES = 8'hC0;
  localparam logic [5:0] MODE_RESET = 6'h00;
  localparam logic [7:0] IO_RESET = 8'h00;
  localparam logic [4:0] RUN_RESET = 5'h00;

  // operating mode codes
  localparam logic [3:0] CODE_NORMAL = 4'h0;
  localparam logic [3:0] CODE_PWM1 = 4'h2;
  localparam logic [3:0] CODE_PWM2 = 4'h3;
  localparam logic [3:0] CODE_PHASE1 = 4'h4;
  localparam logic [3:0] CODE_PHASE4 = 4'h7;
  localparam logic [3:0] CODE_RESET_SYNC = 4'h8;
  localparam logic [3:0] CODE_COMP_PEAK = 4'hD;
  localparam logic [3:0] CODE_COMP_BOTTOM = 4'hE;
  localparam logic [3:0] CODE_COMP_BOTH = 4'hF;

  // I/O control nibble fields
  localparam int NIB_CAPTURE_BIT = 3;
  localparam int NIB_SPECIAL_BIT = 2;
  localparam int NIB_INIT_BIT = 2;
  localparam int NIB_BOTH_EDGE_BIT = 1;
  localparam logic [1:0] ACT_HOLD = 2'h0;
  localparam logic [1:0] ACT_ZERO = 2'h1;
  localparam logic [1:0] ACT_ONE = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;

  typedef enum logic [3:0] {
    mode_normal, mode_pwm1, mode_pwm2, mode_phase, mode_reset_sync,
    mode_comp_peak, mode_comp_bottom, mode_comp_both
  } op_mode_type;

  typedef struct packed {
    logic [NUM_GR-1:0] compare_match;
    logic [NUM_CH-1:0] counter_clear;
    logic ch1_count;
  } timer_events_type;

  typedef struct packed {
    logic [NUM_GR-1:0] level;
    logic [NUM_GR-1:0] oe;
  } pin_drive_type;

endpackage

// ===== verilog/timer_mode_and_io_control.sv
// Purpose: mode selection and per-register I/O control of a five-channel timer
// Assumes: counters, compare logic and buffer transfers live outside this block
// Notes: pins are synchronised by two flops before edge detection
`timescale 1ns/100ps

module timer_mode_and_io_control (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input timer_io_pkg::timer_events_type events,
  input wire logic [19:0] pin_in,
  output timer_io_pkg::pin_drive_type pin_drive,
  output logic [19:0] capture_strobe,
  output logic [4:0] counter_run,
  output logic [4:0] buffer_pair_ac,
  output logic [4:0] buffer_pair_bd,
  output logic [19:0] effective_mode
);

  logic [5:0] mode_reg [timer_io_pkg::NUM_CH];
  logic [7:0] io_reg [timer_io_pkg::NUM_IO];
  logic [4:0] run_bits;
  logic [3:0] eff_code [timer_io_pkg::NUM_CH];
  timer_io_pkg::op_mode_type eff_mode [timer_io_pkg::NUM_CH];
  logic [3:0] nib [timer_io_pkg::NUM_GR];
  logic [19:0] gr_active;
  logic [19:0] pin_sync1;
  logic [19:0] pin_sync2;
  logic [19:0] pin_prev;
  logic [19:0] pin_level;
  logic [19:0] next_level;
  logic [19:0] next_capture;
  logic [31:0] next_rdata;
  logic next_mapped;
  logic ch0_c_event;
  logic [19:0] drive_enable;
  logic [19:0] next_oe;
  logic [19:0] next_eff;
  logic [4:0] next_pair_ac;
  logic [4:0] next_pair_bd;

  // registers that exist: all of channels 0, 3 and 4, only A and B of channels 1 and 2
  localparam logic [19:0] PRESENT_GR = 20'hFF33F;

  // channels 0, 3 and 4 own registers C and D
  function automatic logic has_cd(input int ch);
    return (ch == 0) || (ch == 3) || (ch == 4);
  endfunction

  // first I/O control register of a channel
  function automatic int first_io(input int ch);
    int r;
    r = 0;
    unique case (ch)
      0: r = 0;
      1: r = 2;
      2: r = 3;
      3: r = 4;
      default: r = 6;
    endcase
    return r;
  endfunction

  // mode codes that a channel does not accept fall back to normal operation
  function automatic logic [3:0] legal_code(input int ch, input logic [3:0] c);
    logic [3:0] r;
    r = timer_io_pkg::CODE_NORMAL;
    if ((c == timer_io_pkg::CODE_PWM1)) begin
      r = c;
    end else if (c == timer_io_pkg::CODE_PWM2) begin
      if (ch < 3) begin
        r = c;
      end
    end else if ((c >= timer_io_pkg::CODE_PHASE1) && (c <= timer_io_pkg::CODE_PHASE4)) begin
      if ((ch == 1) || (ch == 2)) begin
        r = c;
      end
    end else if ((c == timer_io_pkg::CODE_RESET_SYNC) || (c == timer_io_pkg::CODE_COMP_PEAK) ||
                 (c == timer_io_pkg::CODE_COMP_BOTTOM) || (c == timer_io_pkg::CODE_COMP_BOTH)) begin
      if (ch == 3) begin
        r = c;
      end
    end
    return r;
  endfunction

  function automatic timer_io_pkg::op_mode_type to_mode(input logic [3:0] c);
    timer_io_pkg::op_mode_type m;
    m = timer_io_pkg::mode_normal;
    if (c == timer_io_pkg::CODE_PWM1) begin
      m = timer_io_pkg::mode_pwm1;
    end else if (c == timer_io_pkg::CODE_PWM2) begin
      m = timer_io_pkg::mode_pwm2;
    end else if ((c >= timer_io_pkg::CODE_PHASE1) && (c <= timer_io_pkg::CODE_PHASE4)) begin
      m = timer_io_pkg::mode_phase;
    end else if (c == timer_io_pkg::CODE_RESET_SYNC) begin
      m = timer_io_pkg::mode_reset_sync;
    end else if (c == timer_io_pkg::CODE_COMP_PEAK) begin
      m = timer_io_pkg::mode_comp_peak;
    end else if (c == timer_io_pkg::CODE_COMP_BOTTOM) begin
      m = timer_io_pkg::mode_comp_bottom;
    end else if (c == timer_io_pkg::CODE_COMP_BOTH) begin
      m = timer_io_pkg::mode_comp_both;
    end
    return m;
  endfunction

  function automatic logic slaves_ch4(input timer_io_pkg::op_mode_type m);
    return (m == timer_io_pkg::mode_reset_sync) || (m == timer_io_pkg::mode_comp_peak) ||
           (m == timer_io_pkg::mode_comp_bottom) || (m == timer_io_pkg::mode_comp_both);
  endfunction

  // word index of an address above a base, or an out-of-range marker
  function automatic int word_index(input logic [11:0] a, input logic [11:0] base, input int n);
    int r;
    r = -1;
    if ((a >= base) && (a[1:0] == 2'h0) && (int'((a - base) >> 2) < n)) begin
      r = int'((a - base) >> 2);
    end
    return r;
  endfunction

  // effective operating mode of each channel
  always_comb begin
    for (int ch = 0; ch < timer_io_pkg::NUM_CH; ch++) begin
      eff_code[ch] = legal_code(ch, mode_reg[ch][timer_io_pkg::MODE_FIELD_LSB +:
                                                 timer_io_pkg::MODE_FIELD_W]);
    end
    if (slaves_ch4(to_mode(eff_code[3]))) begin
      eff_code[4] = eff_code[3];
    end
    for (int ch = 0; ch < timer_io_pkg::NUM_CH; ch++) begin
      eff_mode[ch] = to_mode(eff_code[ch]);
    end
  end

  // per-register function nibble and activity
  always_comb begin
    for (int g = 0; g < timer_io_pkg::NUM_GR; g++) begin
      int ch;
      int letter;
      int r;
      ch = g / 4;
      letter = g % 4;
      r = first_io(ch) + letter / 2;
      nib[g] = (letter % 2 == 1) ? io_reg[r][7:4] : io_reg[r][3:0];
      gr_active[g] = (letter < 2) || has_cd(ch);
      if ((letter == 2) && mode_reg[ch][timer_io_pkg::BUF_PAIR_AC_BIT]) begin
        gr_active[g] = 1'b0;
      end
      if ((letter == 3) && mode_reg[ch][timer_io_pkg::BUF_PAIR_BD_BIT]) begin
        gr_active[g] = 1'b0;
      end
    end
  end

  // input capture sources
  always_comb begin
    for (int g = 0; g < timer_io_pkg::NUM_GR; g++) begin
      logic rise;
      logic fall;
      rise = pin_sync2[g] & ~pin_prev[g];
      fall = ~pin_sync2[g] & pin_prev[g];
      next_capture[g] = 1'b0;
      if (gr_active[g] && nib[g][timer_io_pkg::NIB_CAPTURE_BIT]) begin
        if ((g < 4) && nib[g][timer_io_pkg::NIB_SPECIAL_BIT]) begin
          next_capture[g] = events.ch1_count;
        end else if (nib[g][timer_io_pkg::NIB_BOTH_EDGE_BIT]) begin
          next_capture[g] = rise | fall;
        end else if (nib[g][0]) begin
          next_capture[g] = fall;
        end else begin
          next_capture[g] = rise;
        end
      end
    end
    ch0_c_event = gr_active[2] & ((~nib[2][timer_io_pkg::NIB_CAPTURE_BIT] &
                  events.compare_match[2]) | next_capture[2]);
    if (gr_active[5] && nib[5][timer_io_pkg::NIB_CAPTURE_BIT] &&
        nib[5][timer_io_pkg::NIB_SPECIAL_BIT]) begin
      next_capture[5] = ch0_c_event;
    end
  end

  // output compare pin levels
  always_comb begin
    for (int g = 0; g < timer_io_pkg::NUM_GR; g++) begin
      int ch;
      logic [1:0] act;
      logic init;
      ch = g / 4;
      act = nib[g][1:0];
      init = nib[g][timer_io_pkg::NIB_INIT_BIT];
      next_level[g] = pin_level[g];
      if (gr_active[g] && !nib[g][timer_io_pkg::NIB_CAPTURE_BIT] &&
          (act != timer_io_pkg::ACT_HOLD)) begin
        if (!run_bits[ch]) begin
          next_level[g] = init;
        end else if ((eff_mode[ch] == timer_io_pkg::mode_pwm2) &&
                     events.counter_clear[ch]) begin
          next_level[g] = init;
        end else if (events.compare_match[g]) begin
          unique case (act)
            timer_io_pkg::ACT_ZERO: next_level[g] = 1'b0;
            timer_io_pkg::ACT_ONE: next_level[g] = 1'b1;
            default: next_level[g] = ~pin_level[g];
          endcase
        end
      end
    end
  end

  // pin synchronisers and edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync1 <= 20'h00000;
      pin_sync2 <= 20'h00000;
      pin_prev <= 20'h00000;
    end else begin
      pin_sync1 <= pin_in;
      pin_sync2 <= pin_sync1;
      pin_prev <= pin_sync2;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_level <= 20'h00000;
    end else begin
      pin_level <= next_level;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_strobe <= 20'h00000;
    end else begin
      capture_strobe <= next_capture;
    end
  end

  // register read decode
  always_comb begin
    int mi;
    int ii;
    mi = word_index(paddr, timer_io_pkg::MODE_BASE, timer_io_pkg::NUM_CH);
    ii = word_index(paddr, timer_io_pkg::IO_BASE, timer_io_pkg::NUM_IO);
    next_rdata = 32'h00000000;
    next_mapped = 1'b1;
    if (mi >= 0) begin
      next_rdata[7:0] = timer_io_pkg::MODE_RESERVED_ONES | {2'h0, mode_reg[mi]};
    end else if (ii >= 0) begin
      next_rdata[7:0] = io_reg[ii];
    end else if (paddr == timer_io_pkg::RUN_OFFSET) begin
      next_rdata[4:0] = run_bits;
    end else if (paddr == timer_io_pkg::EFF_MODE_OFFSET) begin
      next_rdata[19:0] = effective_mode;
    end else if (paddr == timer_io_pkg::PIN_LEVEL_OFFSET) begin
      next_rdata[19:0] = pin_level;
    end else begin
      next_mapped = 1'b0;
    end
  end

  // read data and error are taken in the setup cycle and held for the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= pwrite ? 32'h00000000 : next_rdata;
      pslverr <= ~next_mapped;
    end
  end

  // no wait states: every access cycle completes the transfer
  assign pready = psel & penable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int ch = 0; ch < timer_io_pkg::NUM_CH; ch++) begin
        mode_reg[ch] <= timer_io_pkg::MODE_RESET;
      end
    end else if (psel && penable && pwrite) begin
      for (int ch = 0; ch < timer_io_pkg::NUM_CH; ch++) begin
        if (word_index(paddr, timer_io_pkg::MODE_BASE, timer_io_pkg::NUM_CH) == ch) begin
          mode_reg[ch] <= has_cd(ch) ? pwdata[5:0] : {2'h0, pwdata[3:0]};
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int r = 0; r < timer_io_pkg::NUM_IO; r++) begin
        io_reg[r] <= timer_io_pkg::IO_RESET;
      end
    end else if (psel && penable && pwrite) begin
      for (int r = 0; r < timer_io_pkg::NUM_IO; r++) begin
        if (word_index(paddr, timer_io_pkg::IO_BASE, timer_io_pkg::NUM_IO) == r) begin
          io_reg[r] <= pwdata[7:0];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_bits <= timer_io_pkg::RUN_RESET;
    end else if (psel && penable && pwrite && (paddr == timer_io_pkg::RUN_OFFSET)) begin
      run_bits <= pwdata[4:0];
    end
  end

  // next values of the status outputs
  always_comb begin
    for (int g = 0; g < timer_io_pkg::NUM_GR; g++) begin
      next_oe[g] = gr_active[g] & ~nib[g][timer_io_pkg::NIB_CAPTURE_BIT];
    end
    for (int ch = 0; ch < timer_io_pkg::NUM_CH; ch++) begin
      next_eff[ch*4 +: 4] = eff_code[ch];
      next_pair_ac[ch] = mode_reg[ch][timer_io_pkg::BUF_PAIR_AC_BIT];
      next_pair_bd[ch] = mode_reg[ch][timer_io_pkg::BUF_PAIR_BD_BIT];
    end
  end

  // status outputs are registered, so they trail a register write by one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_enable <= PRESENT_GR;
      effective_mode <= 20'h00000;
      buffer_pair_ac <= 5'h00;
      buffer_pair_bd <= 5'h00;
    end else begin
      drive_enable <= next_oe;
      effective_mode <= next_eff;
      buffer_pair_ac <= next_pair_ac;
      buffer_pair_bd <= next_pair_bd;
    end
  end

  // pin levels and their enables travel together
  assign pin_drive = '{level: pin_level, oe: drive_enable};
  assign counter_run = run_bits;

endmodule
